//--- idwc_pkg.sv
package idwc_pkg;
  // peripheral idle control bit positions
  localparam int P_OS_TIMER = 0;
  localparam int P_GPIO = 1;
  localparam int P_PGPIO = 2;
  localparam int P_PLLDIV = 3;
  localparam int P_BSP0 = 4;
  localparam int P_BSP1 = 5;
  localparam int P_I2C = 6;
  localparam int P_UART = 7;
  localparam int P_EXT_MEM_INTERFACE = 8;
  localparam int NPERIPH = 9;
  // idle configuration bit positions
  localparam int C_CPU = 0;
  localparam int C_MP = 1;
  localparam int C_PER = 3;
  localparam int C_CLK = 4;
  localparam int C_CLKE = 9;
  localparam int CFGW = 10;
  // master idle control bit positions
  localparam int M_DMA = 0;
  localparam int M_HPI = 1;
  // wake enable bit positions: four external irqs then nmi
  localparam int WK_NMI = 4;
  localparam int WKW = 5;
  // oscillator stabilization
  localparam int OSC_STAB_REF_CYCLES = 41032;
  localparam logic [15:0] STAB_ZERO = 16'h0000;
  localparam logic [CFGW-1:0] CFG_RESET = 10'h000;
  localparam logic [NPERIPH-1:0] PER_RESET = 9'h000;
  localparam logic [1:0] MST_RESET = 2'h0;
  typedef enum logic [1:0] {
    IDWC_RUN = 2'b00,
    IDWC_CPU_IDLE = 2'b01,
    IDWC_OSC_STAB = 2'b10
  } idwc_cpu_t;
endpackage

//--- idwc_gate.sv
`timescale 1ns/1ps
// one module's idle handshake: request, wait for acknowledge, then gate clock
module idwc_gate (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic req_in,
  input wire logic can_idle_in,
  input wire logic ack_in,
  output logic req_out,
  output logic gated_out
);
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      req_out <= 1'b0;
      gated_out <= 1'b0;
    end else if (!req_in) begin
      req_out <= 1'b0;
      gated_out <= 1'b0;
    end else begin
      if (can_idle_in || req_out)
        req_out <= 1'b1;
      // clock is stopped only once the module confirms it is quiet
      if (req_out && ack_in)
        gated_out <= 1'b1;
    end
  end
endmodule

//--- idwc_top.sv
`timescale 1ns/1ps
// Contract
// - os timer, gpio, parallel gpio, pll divider idle at once when requested.
// - external-clock serial ports idle at once if quiet, else after activity.
// - internal-clock serial port idles only if tx and rx resets are zero.
// - idle serial port auto-wakes for dma transfers, then returns to idle.
// - two-wire and uart idle at once if quiet, else after transfer.
// - pll core and oscillator power down only if software preselected it.
// - memory interface idles after current dma transfer, or at once.
// - hardware reset returns every module and domain to active.
// - cpu wakes on nmi or external irq enabled in either enable register.
// - memory interface wakes with the cpu when both were idle.
// - clearing master port bit then idle instruction wakes dma and host port.
// - writing zero to a master idle bit wakes that module directly.
// - clearing peripheral domain bit then idle wakes all peripherals.
// - writing zero to a peripheral idle bit wakes it directly.
// - all-zero configuration then idle enables all clocks, wakes all.
// - after idle three, software restarts pll, then pll sources clocks.
// - oscillator wakes with clock module on a wake-enabled irq or nmi.
// - 41032 reference cycles of stabilization before execution resumes.
// - after oscillator-off idle, software clears pll and osc power-down bits.
// - control register ones apply only when the idle instruction runs; written zeros apply at once.
module idwc_top #(
  parameter int REF_CLK_DIV = 1,
  parameter int STAB_CYCLES = idwc_pkg::OSC_STAB_REF_CYCLES,
  parameter int NPER = idwc_pkg::NPERIPH
) (
  input wire logic MCLK_IN,
  input wire logic RESET_IN,
  input wire logic IDLE_INSTR_IN,
  input wire logic [idwc_pkg::CFGW-1:0] IDLE_CONFIG_REG_IN,
  input wire logic [NPER-1:0] PERIPH_IDLE_CTRL_REG_IN,
  input wire logic PERIPH_IDLE_CTRL_WR_IN,
  input wire logic [1:0] MASTER_IDLE_CTRL_REG_IN,
  input wire logic MASTER_IDLE_CTRL_WR_IN,
  input wire logic PLL_POWER_DOWN_BIT_IN,
  input wire logic OSC_POWER_DOWN_BIT_IN,
  input wire logic PLL_ENABLE_BIT_IN,
  input wire logic PLL_LOCK_IN,
  input wire logic [idwc_pkg::WKW-1:0] OSC_WAKE_ENABLE_REG_IN,
  input wire logic [15:0] IRQ_ENABLE_REG_A_IN,
  input wire logic [15:0] IRQ_ENABLE_REG_B_IN,
  input wire logic [15:0] IRQ_PENDING_IN,
  input wire logic [3:0] EXT_IRQ_IN,
  input wire logic NMI_IN,
  input wire logic [NPER-1:0] PERIPH_BUSY_IN,
  input wire logic [NPER-1:0] PERIPH_ACK_IN,
  input wire logic [1:0] BSP_EXT_CLK_IN,
  input wire logic [1:0] TX_RESET_CTL_IN,
  input wire logic [1:0] RX_RESET_CTL_IN,
  input wire logic [1:0] BSP_XFER_IN,
  input wire logic [1:0] MASTER_BUSY_IN,
  input wire logic [1:0] MASTER_ACK_IN,
  output logic [NPER-1:0] PERIPH_IDLE_REQ_OUT,
  output logic [NPER-1:0] PERIPH_CLK_GATE_OUT,
  output logic [1:0] MASTER_IDLE_REQ_OUT,
  output logic [1:0] MASTER_CLK_GATE_OUT,
  output logic CPU_IDLE_OUT,
  output logic CPU_RUN_OUT,
  output logic CLOCKGEN_IDLE_OUT,
  output logic PLL_POWERED_DOWN_OUT,
  output logic OSC_POWERED_DOWN_OUT,
  output logic PLL_CLK_SELECT_OUT
);
  // stabilization counter width; default covers 41032
  localparam int STAB_W = 16;
  localparam logic [STAB_W-1:0] STAB_LOAD = STAB_W'(STAB_CYCLES - 1);

  // irq inputs come from pins or other clock domains
  logic [3:0] irq_s1, irq_s2;
  logic nmi_s1, nmi_s2;
  logic [1:0] bsp_x1, bsp_x2;
  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      irq_s1 <= 4'h0;
      irq_s2 <= 4'h0;
      nmi_s1 <= 1'b0;
      nmi_s2 <= 1'b0;
      bsp_x1 <= 2'h0;
      bsp_x2 <= 2'h0;
    end else begin
      irq_s1 <= EXT_IRQ_IN;
      irq_s2 <= irq_s1;
      nmi_s1 <= NMI_IN;
      nmi_s2 <= nmi_s1;
      bsp_x1 <= BSP_XFER_IN;
      bsp_x2 <= bsp_x1;
    end
  end

  // reference clock divider enable
  // one-cycle enable, so the count needs no second clock domain
  logic [7:0] div_cnt;
  logic ref_tick;
  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      div_cnt <= 8'h00;
      ref_tick <= 1'b0;
    end else if (div_cnt >= 8'(REF_CLK_DIV - 1)) begin
      div_cnt <= 8'h00;
      ref_tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 8'h01;
      ref_tick <= 1'b0;
    end
  end

  // applied configuration, latched on the idle instruction; cpu and clock bits clear on resume
  logic [idwc_pkg::CFGW-1:0] cfg;
  logic [NPER-1:0] per_req;
  logic [1:0] mst_req;
  logic cpu_wake;
  // cpu leaving idle by either path: direct wake or end of the oscillator count
  logic cpu_resume;
  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      cfg <= idwc_pkg::CFG_RESET;
    end else if (IDLE_INSTR_IN) begin
      cfg <= IDLE_CONFIG_REG_IN;
    end else if (cpu_resume) begin
      cfg[idwc_pkg::C_CPU] <= 1'b0;
      cfg[idwc_pkg::C_CLK] <= 1'b0;
      cfg[idwc_pkg::C_CLKE] <= 1'b0;
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      per_req <= idwc_pkg::PER_RESET;
    end else if (IDLE_INSTR_IN) begin
      // domain bit clear wakes every peripheral
      per_req <= IDLE_CONFIG_REG_IN[idwc_pkg::C_PER] ? PERIPH_IDLE_CTRL_REG_IN
                                                     : idwc_pkg::PER_RESET;
    end else begin
      if (PERIPH_IDLE_CTRL_WR_IN)
        per_req <= per_req & PERIPH_IDLE_CTRL_REG_IN; // zero wakes directly
      // the oscillator-path wake must release the memory interface as well
      if (cpu_resume && cfg[idwc_pkg::C_CPU])
        per_req[idwc_pkg::P_EXT_MEM_INTERFACE] <= 1'b0;
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      mst_req <= idwc_pkg::MST_RESET;
    end else if (IDLE_INSTR_IN) begin
      mst_req <= IDLE_CONFIG_REG_IN[idwc_pkg::C_MP] ? MASTER_IDLE_CTRL_REG_IN
                                                    : idwc_pkg::MST_RESET;
    end else if (MASTER_IDLE_CTRL_WR_IN) begin
      mst_req <= mst_req & MASTER_IDLE_CTRL_REG_IN;
    end
  end

  // per-module idle permission
  logic [NPER-1:0] can_idle;
  logic [NPER-1:0] per_eff_req;
  always_comb begin
    can_idle = '0;
    per_eff_req = per_req;
    // these stop with no wait
    can_idle[idwc_pkg::P_OS_TIMER] = 1'b1;
    can_idle[idwc_pkg::P_GPIO] = 1'b1;
    can_idle[idwc_pkg::P_PGPIO] = 1'b1;
    can_idle[idwc_pkg::P_PLLDIV] = 1'b1;
    for (int i = 0; i < 2; i++) begin
      if (BSP_EXT_CLK_IN[i])
        can_idle[idwc_pkg::P_BSP0 + i] = !PERIPH_BUSY_IN[idwc_pkg::P_BSP0 + i];
      else
        can_idle[idwc_pkg::P_BSP0 + i] = !TX_RESET_CTL_IN[i] && !RX_RESET_CTL_IN[i];
      // a new transfer lifts the request; it returns once the transfer ends
      if (bsp_x2[i])
        per_eff_req[idwc_pkg::P_BSP0 + i] = 1'b0;
    end
    can_idle[idwc_pkg::P_I2C] = !PERIPH_BUSY_IN[idwc_pkg::P_I2C];
    can_idle[idwc_pkg::P_UART] = !PERIPH_BUSY_IN[idwc_pkg::P_UART];
    can_idle[idwc_pkg::P_EXT_MEM_INTERFACE] = !PERIPH_BUSY_IN[idwc_pkg::P_EXT_MEM_INTERFACE];
  end

  // the internal-clock port re-idles once its transfer flag drops, whatever its busy input says
  genvar g;
  generate
    for (g = 0; g < NPER; g++) begin : g_per
      idwc_gate u_gate (
        .clk_in(MCLK_IN),
        .rst_in(RESET_IN),
        .req_in(per_eff_req[g]),
        .can_idle_in(can_idle[g]),
        .ack_in(PERIPH_ACK_IN[g]),
        .req_out(PERIPH_IDLE_REQ_OUT[g]),
        .gated_out(PERIPH_CLK_GATE_OUT[g])
      );
    end
    // host port may idle while busy: its traffic is left to software
    for (g = 0; g < 2; g++) begin : g_mst
      idwc_gate u_gate (
        .clk_in(MCLK_IN),
        .rst_in(RESET_IN),
        .req_in(mst_req[g] && !(g == idwc_pkg::M_DMA && |bsp_x2)),
        .can_idle_in(!MASTER_BUSY_IN[g] || g == idwc_pkg::M_HPI),
        .ack_in(MASTER_ACK_IN[g]),
        .req_out(MASTER_IDLE_REQ_OUT[g]),
        .gated_out(MASTER_CLK_GATE_OUT[g])
      );
    end
  endgenerate

  // wake sources
  logic irq_enabled_wake;
  logic osc_wake;
  assign irq_enabled_wake = |(IRQ_PENDING_IN & (IRQ_ENABLE_REG_A_IN | IRQ_ENABLE_REG_B_IN));
  // only irqs already enabled by software can wake
  assign osc_wake = (|(irq_s2 & OSC_WAKE_ENABLE_REG_IN[3:0]) && irq_enabled_wake)
                    || (nmi_s2 && OSC_WAKE_ENABLE_REG_IN[idwc_pkg::WK_NMI]);

  // cpu / clock generator sequencing
  idwc_pkg::idwc_cpu_t state, next_state;
  logic [STAB_W-1:0] stab_cnt;
  logic clk_idle;
  assign clk_idle = IDLE_CONFIG_REG_IN[idwc_pkg::C_CLK]
                    && IDLE_CONFIG_REG_IN[idwc_pkg::C_CLKE];
  assign cpu_wake = (state == idwc_pkg::IDWC_CPU_IDLE) && !OSC_POWERED_DOWN_OUT
                    && (nmi_s2 || irq_enabled_wake);
  assign cpu_resume = cpu_wake || (state == idwc_pkg::IDWC_OSC_STAB
                                   && next_state == idwc_pkg::IDWC_RUN);

  always_comb begin
    next_state = state;
    unique case (state)
      idwc_pkg::IDWC_RUN:
        if (IDLE_INSTR_IN && IDLE_CONFIG_REG_IN[idwc_pkg::C_CPU])
          next_state = idwc_pkg::IDWC_CPU_IDLE;
      idwc_pkg::IDWC_CPU_IDLE:
        if (OSC_POWERED_DOWN_OUT && osc_wake)
          next_state = idwc_pkg::IDWC_OSC_STAB;
        else if (cpu_wake)
          next_state = idwc_pkg::IDWC_RUN;
      idwc_pkg::IDWC_OSC_STAB:
        if (ref_tick && stab_cnt == idwc_pkg::STAB_ZERO)
          next_state = idwc_pkg::IDWC_RUN;
      default:
        next_state = idwc_pkg::IDWC_RUN;
    endcase
  end

  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN)
      state <= idwc_pkg::IDWC_OSC_STAB; // reset also waits out the count
    else
      state <= next_state;
  end

  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN)
      stab_cnt <= STAB_LOAD;
    else if (state != idwc_pkg::IDWC_OSC_STAB)
      // reloaded outside the count, so every entry waits the full period
      stab_cnt <= STAB_LOAD;
    else if (ref_tick && stab_cnt != idwc_pkg::STAB_ZERO)
      stab_cnt <= stab_cnt - 1'b1;
  end

  always_ff @(posedge MCLK_IN) begin
    CPU_IDLE_OUT <= !RESET_IN && next_state == idwc_pkg::IDWC_CPU_IDLE;
    CPU_RUN_OUT <= !RESET_IN && next_state == idwc_pkg::IDWC_RUN;
  end

  // power-down only if software chose it before the idle instruction
  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      CLOCKGEN_IDLE_OUT <= 1'b0;
      PLL_POWERED_DOWN_OUT <= 1'b0;
      OSC_POWERED_DOWN_OUT <= 1'b0;
    end else if (IDLE_INSTR_IN && IDLE_CONFIG_REG_IN[idwc_pkg::C_CPU] && clk_idle) begin
      CLOCKGEN_IDLE_OUT <= 1'b1;
      PLL_POWERED_DOWN_OUT <= PLL_POWER_DOWN_BIT_IN;
      OSC_POWERED_DOWN_OUT <= OSC_POWER_DOWN_BIT_IN;
    end else if (osc_wake && state == idwc_pkg::IDWC_CPU_IDLE) begin
      // clock module and oscillator wake together
      CLOCKGEN_IDLE_OUT <= 1'b0;
      OSC_POWERED_DOWN_OUT <= 1'b0;
    end else if (cpu_wake) begin
      CLOCKGEN_IDLE_OUT <= 1'b0;
    end else if (state == idwc_pkg::IDWC_RUN) begin
      // pll stays down until software clears its power-down bit
      if (!PLL_POWER_DOWN_BIT_IN)
        PLL_POWERED_DOWN_OUT <= 1'b0;
    end
  end

  // pll selected as clock source only when enabled, locked and powered
  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN)
      PLL_CLK_SELECT_OUT <= 1'b0;
    else
      PLL_CLK_SELECT_OUT <= PLL_ENABLE_BIT_IN && PLL_LOCK_IN && !PLL_POWERED_DOWN_OUT
                            && !CLOCKGEN_IDLE_OUT;
  end
endmodule

//--- idwc_top_sva.sv
`timescale 1ns/1ps
// port-level checks of the idle sequencer
module idwc_top_sva #(
  parameter int STAB_CYCLES = 20,
  parameter int REF_CLK_DIV = 1
) (
  input wire logic MCLK_IN,
  input wire logic RESET_IN,
  input wire logic IDLE_INSTR_IN,
  input wire logic [idwc_pkg::CFGW-1:0] IDLE_CONFIG_REG_IN,
  input wire logic [8:0] PERIPH_IDLE_CTRL_REG_IN,
  input wire logic NMI_IN,
  input wire logic [8:0] PERIPH_BUSY_IN,
  input wire logic [8:0] PERIPH_ACK_IN,
  input wire logic [1:0] BSP_EXT_CLK_IN,
  input wire logic [1:0] TX_RESET_CTL_IN,
  input wire logic [1:0] RX_RESET_CTL_IN,
  input wire logic [8:0] PERIPH_IDLE_REQ_OUT,
  input wire logic [8:0] PERIPH_CLK_GATE_OUT,
  input wire logic CPU_IDLE_OUT,
  input wire logic CPU_RUN_OUT,
  input wire logic CLOCKGEN_IDLE_OUT,
  input wire logic OSC_POWERED_DOWN_OUT
);
  // margin of a few cycles for the reset and sync stages
  localparam int RUN_LIM = STAB_CYCLES * REF_CLK_DIV + 6;
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (RESET_IN);
  reset_quiet_a: assert property (disable iff (1'b0) RESET_IN |=>
    !CPU_RUN_OUT && !CPU_IDLE_OUT && PERIPH_IDLE_REQ_OUT == 9'h000) else $error("reset left state");
  boot_run_a: assert property ($fell(RESET_IN) |-> ##[1:RUN_LIM] CPU_RUN_OUT)
    else $error("no run after boot");
  fast_idle_a: assert property (IDLE_INSTR_IN && CPU_RUN_OUT && IDLE_CONFIG_REG_IN[3] &&
    PERIPH_IDLE_CTRL_REG_IN[0] |-> ##2 PERIPH_IDLE_REQ_OUT[0]) else $error("timer idle late");
  bsp_refuse_a: assert property ($rose(PERIPH_IDLE_REQ_OUT[4]) |->
    $past(BSP_EXT_CLK_IN[0] | ~(TX_RESET_CTL_IN[0] | RX_RESET_CTL_IN[0])))
    else $error("serial port idled in reset ctl");
  uart_wait_a: assert property ($rose(PERIPH_IDLE_REQ_OUT[7]) |-> !$past(PERIPH_BUSY_IN[7]))
    else $error("uart idled while busy");
  nmi_wake_a: assert property (CPU_IDLE_OUT && !CLOCKGEN_IDLE_OUT && !OSC_POWERED_DOWN_OUT
    && $rose(NMI_IN) |-> ##[1:5] CPU_RUN_OUT) else $error("cpu missed nmi");
  idle_on_instr_a: assert property ($rose(CPU_IDLE_OUT) |-> $past(IDLE_INSTR_IN))
    else $error("cpu idled without instr");
  gate_after_ack_a: assert property ((PERIPH_CLK_GATE_OUT & ~$past(PERIPH_CLK_GATE_OUT) &
    ~$past(PERIPH_ACK_IN & PERIPH_IDLE_REQ_OUT)) == 9'h000) else $error("gate before ack");
  run_c: cover property ($rose(CPU_RUN_OUT));
  gate_c: cover property ($rose(PERIPH_CLK_GATE_OUT[0]));
  osc_c: cover property ($rose(OSC_POWERED_DOWN_OUT));
endmodule
bind idwc_top idwc_top_sva #(.STAB_CYCLES(STAB_CYCLES), .REF_CLK_DIV(REF_CLK_DIV)) i_sva (
  .MCLK_IN(MCLK_IN), .RESET_IN(RESET_IN), .IDLE_INSTR_IN(IDLE_INSTR_IN),
  .IDLE_CONFIG_REG_IN(IDLE_CONFIG_REG_IN), .PERIPH_IDLE_CTRL_REG_IN(PERIPH_IDLE_CTRL_REG_IN),
  .NMI_IN(NMI_IN), .PERIPH_BUSY_IN(PERIPH_BUSY_IN), .PERIPH_ACK_IN(PERIPH_ACK_IN),
  .BSP_EXT_CLK_IN(BSP_EXT_CLK_IN), .TX_RESET_CTL_IN(TX_RESET_CTL_IN),
  .RX_RESET_CTL_IN(RX_RESET_CTL_IN), .PERIPH_IDLE_REQ_OUT(PERIPH_IDLE_REQ_OUT),
  .PERIPH_CLK_GATE_OUT(PERIPH_CLK_GATE_OUT), .CPU_IDLE_OUT(CPU_IDLE_OUT),
  .CPU_RUN_OUT(CPU_RUN_OUT), .CLOCKGEN_IDLE_OUT(CLOCKGEN_IDLE_OUT),
  .OSC_POWERED_DOWN_OUT(OSC_POWERED_DOWN_OUT)
);

//--- idwc_partner.sv
`timescale 1ns/1ps
// gated modules: acknowledge one cycle after the request, never sooner
module idwc_partner (
  input wire logic clk_in,
  input wire logic [8:0] preq_in,
  input wire logic [1:0] mreq_in,
  output logic [8:0] pack_out = 9'h000,
  output logic [1:0] mack_out = 2'h0
);
  always_ff @(posedge clk_in) begin
    pack_out <= preq_in;
    mack_out <= mreq_in;
  end
endmodule

//--- idwc_top_tb.sv
`timescale 1ns/1ps
module idwc_top_tb;
  localparam int STAB = 20;
  logic clk = 1'b0, rst = 1'b1, instr = 1'b0, per_wr = 1'b0, mst_wr = 1'b0, nmi = 1'b0;
  logic pll_pd = 1'b0, osc_pd = 1'b0, pll_en = 1'b0, lock = 1'b0;
  logic [9:0] cfg = 10'h000;
  logic [8:0] per = 9'h000, busy = 9'h000, pack, preq, pgate;
  logic [1:0] mst = 2'h0, bext = 2'h0, txr = 2'h0, rxr = 2'h0, xfer = 2'h0, mack, mreq, mgate;
  logic [4:0] wk = 5'h00;
  logic [3:0] eirq = 4'h0;
  logic [15:0] iea = 16'h0000, ieb = 16'h0000, pend = 16'h0000;
  logic cidle, crun, cgidle, pllpd, oscpd, pllsel;
  int n_mismatch = 0, num_checks = 0, cyc = 0;
  idwc_top #(.STAB_CYCLES(STAB)) i_dut (.MCLK_IN(clk), .RESET_IN(rst), .IDLE_INSTR_IN(instr),
    .IDLE_CONFIG_REG_IN(cfg), .PERIPH_IDLE_CTRL_REG_IN(per), .PERIPH_IDLE_CTRL_WR_IN(per_wr),
    .MASTER_IDLE_CTRL_REG_IN(mst), .MASTER_IDLE_CTRL_WR_IN(mst_wr), .PLL_POWER_DOWN_BIT_IN(pll_pd),
    .OSC_POWER_DOWN_BIT_IN(osc_pd), .PLL_ENABLE_BIT_IN(pll_en), .PLL_LOCK_IN(lock),
    .OSC_WAKE_ENABLE_REG_IN(wk), .IRQ_ENABLE_REG_A_IN(iea), .IRQ_ENABLE_REG_B_IN(ieb),
    .IRQ_PENDING_IN(pend), .EXT_IRQ_IN(eirq), .NMI_IN(nmi), .PERIPH_BUSY_IN(busy),
    .PERIPH_ACK_IN(pack), .BSP_EXT_CLK_IN(bext), .TX_RESET_CTL_IN(txr), .RX_RESET_CTL_IN(rxr),
    .BSP_XFER_IN(xfer), .MASTER_BUSY_IN(2'h0), .MASTER_ACK_IN(mack), .PERIPH_IDLE_REQ_OUT(preq),
    .PERIPH_CLK_GATE_OUT(pgate), .MASTER_IDLE_REQ_OUT(mreq), .MASTER_CLK_GATE_OUT(mgate),
    .CPU_IDLE_OUT(cidle), .CPU_RUN_OUT(crun), .CLOCKGEN_IDLE_OUT(cgidle),
    .PLL_POWERED_DOWN_OUT(pllpd), .OSC_POWERED_DOWN_OUT(oscpd), .PLL_CLK_SELECT_OUT(pllsel));
  idwc_partner i_mod (.clk_in(clk), .preq_in(preq), .mreq_in(mreq), .pack_out(pack),
    .mack_out(mack));
  initial forever #2 clk = ~clk;
  task tick; @(posedge clk); #1; endtask
  task pulse; instr = 1'b1; tick; instr = 1'b0; repeat (5) tick; endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task wait_run(output int n);
    n = 0;
    while (crun !== 1'b1 && n < 80) begin
      tick;
      n++;
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      final_report;
    end
  end
  task t_boot;
    int n;
    wait_run(n);
    chk("boot_stab", 16'h0001, 16'(n >= STAB && crun === 1'b1));
    $display("test boot done");
  endtask
  task t_periph;
    bext = 2'b10; txr = 2'b01; busy = 9'h0a0; cfg = 10'h008; per = 9'h1ff;
    repeat (3) tick;
    chk("req_pending", 16'h0000, 16'(preq));
    pulse;
    chk("req_busy", 16'h014f, 16'(preq));
    busy = 9'h000; repeat (4) tick;
    chk("req_quiet", 16'h01ef, 16'(preq));
    chk("gate", 16'h01ef, 16'(pgate));
    xfer = 2'b10; repeat (4) tick;
    chk("auto_wake", 16'h0000, 16'(preq[5]));
    xfer = 2'b00; repeat (6) tick;
    chk("auto_idle", 16'h0001, 16'(preq[5]));
    per = 9'h1fe; per_wr = 1'b1; tick; per_wr = 1'b0; repeat (4) tick;
    chk("direct_wake", 16'h01ee, 16'(preq));
    txr = 2'b00;
    rxr = 2'b01;
    repeat (3) tick;
    chk("rx_refuse", 16'h0000, 16'(preq[4]));
    rxr = 2'b00;
    repeat (3) tick;
    chk("bsp_quiet", 16'h0001, 16'(preq[4]));
    cfg = 10'h000; pulse;
    chk("domain_wake", 16'h0000, 16'(preq | pgate));
    per = 9'h000; $display("test periph done");
  endtask
  task t_master;
    mst = 2'b11; cfg = 10'h002; pulse;
    chk("mst_gate", 16'h0003, 16'(mreq & mgate));
    mst = 2'b10; mst_wr = 1'b1; tick; mst_wr = 1'b0; repeat (4) tick;
    chk("dma_wake", 16'h0002, 16'(mreq | mgate));
    cfg = 10'h000; pulse;
    chk("mport_wake", 16'h0000, 16'(mreq | mgate));
    mst = 2'b00; $display("test master done");
  endtask
  task t_cpu;
    cfg = 10'h009; per = 9'h100; pend = 16'h0018; pulse;
    chk("cpu_masked", 16'h0005, 16'({cidle, crun, preq[8]}));
    iea = 16'h0008; repeat (4) tick;
    chk("irq_wake", 16'h0001, 16'({cidle, crun}));
    chk("ext_mem_interface_follow", 16'h0000, 16'(preq[8] | pgate[8]));
    iea = 16'h0000;
    pulse;
    ieb = 16'h0010;
    repeat (4) tick;
    chk("irq_b_wake", 16'h0001, 16'({cidle, crun}));
    pend = 16'h0000; pulse; nmi = 1'b1; repeat (5) tick; nmi = 1'b0;
    chk("nmi_wake", 16'h0001, 16'({cidle, crun}));
    cfg = 10'h000; per = 9'h000; pulse;
    $display("test cpu done");
  endtask
  task t_osc;
    int n;
    pll_pd = 1'b1; osc_pd = 1'b1; wk = 5'h10; cfg = 10'h03ff; pulse;
    chk("power_down", 16'h0007, 16'({cgidle, pllpd, oscpd}));
    nmi = 1'b1; wait_run(n); nmi = 1'b0;
    chk("osc_stab", 16'h0001, 16'(n >= STAB && crun === 1'b1));
    wk = 5'h01;
    pend = 16'h0004;
    iea = 16'h0004;
    per = 9'h100;
    pulse;
    chk("irq_osc_down", 16'h0001, 16'(oscpd));
    eirq = 4'h1;
    wait_run(n);
    eirq = 4'h0;
    chk("irq_osc_stab", 16'h0001, 16'(n >= STAB && crun === 1'b1));
    tick;
    chk("ext_mem_interface_osc", 16'h0000, 16'(preq[8]));
    pend = 16'h0000;
    iea = 16'h0000;
    per = 9'h000;
    cfg = 10'h000; pulse;
    chk("all_wake", 16'h0000, 16'({cidle, cgidle, preq}));
    pll_pd = 1'b0; osc_pd = 1'b0; lock = 1'b1; repeat (2) tick; pll_en = 1'b1; repeat (3) tick;
    chk("pll_source", 16'h0004, 16'({pllsel, pllpd, oscpd}));
    $display("test osc done");
  endtask
  task t_reset;
    cfg = 10'h001; pulse; rst = 1'b1; repeat (3) tick;
    chk("reset_out", 16'h0000, 16'({cidle, crun, preq, mreq}));
    rst = 1'b0; cfg = 10'h000; t_boot;
    $display("test reset done");
  endtask
  initial begin
    repeat (3) tick;
    rst = 1'b0;
    t_boot;
    t_periph;
    t_master;
    t_cpu;
    t_osc;
    t_reset;
    final_report;
  end
endmodule
